// file: core/smsc_core.sv
// serial port core: master or slave shift engine, rate generator and
// timer, error flags and classic wishbone register slave.
// assumes sys_clk 25 MHz; pins are resolved outside from o and oe.
//
// Behaviour
// - four formats: phase and idle level select edges
// - idle level only inverts clock, timing unchanged
// - master presents bit half period before sampling
// - shared lines may run open drain
// - one master; only selected slave drives miso
// - master with select as input sees it low: collision, write-one-clear
// - slave when enabled, not master, select input
// - slave ignores generator, reload, timer, select value
// - slave shifts whatever data register holds
// - write while busy: unchanged, overrun, write-one-clear
// - early select release aborts, sets abort and irq
// - after abort restart at bit seven; write-one-clear
// - interrupt on every character, length one to eight
// - slave completes characters under continuous select
// - write one clears pending; needed for more
// - force bit sets pending and interrupt request
// - disabled port: timer time-out interrupts without pending flag
// - bit rate is clock over twice reload
// - reload zero counts as 65536
// - disabled port: generator times reload periods
// - length code zero is eight bits
// - msb first from bit seven, last into bit zero
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "smsc_consts.svh"

module smsc_core (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_b_i,
    output logic ss_b_o,
    output logic ss_b_oe,
    output logic irq_out
);

    // ***************************************************************
    // reset and pin synchronisers
    // ***************************************************************
    logic [1:0] rsync;
    logic rst_n;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [1:0] pin_s3;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsync <= 2'h0;
        end else begin
            rsync <= {rsync[0], 1'h1};
        end
    end
    assign rst_n = rsync[1];

    // order: sck, select, mosi, miso
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
            pin_s3 <= 2'h3;
        end else if (ce) begin
            pin_s1 <= {sck_i, ss_b_i, mosi_i, miso_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2[3:2];
        end
    end

    wire sck_s = pin_s2[3];
    wire ss_s = pin_s2[2];
    wire sck_rise = sck_s & ~pin_s3[1];
    wire sck_fall = ~sck_s & pin_s3[1];
    wire ss_rise = ss_s & ~pin_s3[0];

    // ***************************************************************
    // register bus decode
    // ***************************************************************
    smsc_pkg::smsc_ctl_t ctl;
    smsc_pkg::smsc_mode_t mode;
    smsc_pkg::smsc_mstate_t mst;
    logic [7:0] brh;
    logic [7:0] brl;
    logic [7:0] sh;
    logic irq;
    logic overrun_flag;
    logic col;
    logic abort_flag;

    wire [2:0] idx = wb_adr_i[4:2];
    wire mapped = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0) && (idx <= `SMSC_IDX_BRL);
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] & mapped;
    wire wr_data = wr && (idx == `SMSC_IDX_DATA);
    wire wr_ctl = wr && (idx == `SMSC_IDX_CTL);
    wire wr_stat = wr && (idx == `SMSC_IDX_STAT);
    wire wr_mode = wr && (idx == `SMSC_IDX_MODE);
    wire wr_brh = wr && (idx == `SMSC_IDX_BRH);
    wire wr_brl = wr && (idx == `SMSC_IDX_BRL);

    // ***************************************************************
    // mode decode
    // ***************************************************************
    wire en = ctl.port_enable;
    wire master = en & ctl.master_mode_enable;
    wire slave = en & ~ctl.master_mode_enable & ~mode.select_pin_direction;
    wire ss_sel = ~ss_s;
    wire [3:0] len = (mode.character_length == 3'h0) ? `SMSC_LEN_FULL
                   : {1'h0, mode.character_length};
    wire mst_busy = (mst == smsc_pkg::M_SHIFT);
    logic sact;
    wire busy = mst_busy | sact;

    // ***************************************************************
    // rate generator and timer
    // ***************************************************************
    logic [16:0] cnt;
    logic [4:0] hcnt;
    wire [16:0] reload = {({brh, brl} == 16'h0000), brh, brl};
    wire timer_on = ~en & ctl.timer_interrupt_enable;
    wire run = mst_busy | timer_on;
    wire tick = run && (cnt == reload);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 17'h00001;
        end else if (ce) begin
            cnt <= (!run || tick) ? 17'h00001 : cnt + 17'h00001;
        end
    end

    // ***************************************************************
    // shift engine
    // ***************************************************************
    logic [3:0] bcnt;
    logic smp;
    logic outb;
    logic act;
    wire m_lead = tick & mst_busy & ~hcnt[0];
    wire m_trail = tick & mst_busy & hcnt[0];
    wire s_lead = slave & ss_sel & (ctl.clock_idle_level ? sck_fall : sck_rise);
    wire s_trail = slave & ss_sel & (ctl.clock_idle_level ? sck_rise : sck_fall);
    wire lead = m_lead | s_lead;
    wire trail = m_trail | s_trail;
    wire din = master ? pin_s2[0] : pin_s2[1];
    wire shift_in = ctl.phase ? din : smp;
    wire done = trail && ((bcnt + 4'h1) == len);
    wire abort_ev = slave & sact & ss_rise;
    wire start = master & wr_data & ~busy;
    wire dout = ctl.phase ? outb : sh[7];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mst <= smsc_pkg::M_IDLE;
        end else if (ce) begin
            unique case (mst)
                smsc_pkg::M_IDLE: begin
                    if (start) begin
                        mst <= smsc_pkg::M_SHIFT;
                    end
                end
                smsc_pkg::M_SHIFT: begin
                    if (!master || done) begin
                        mst <= smsc_pkg::M_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt <= 5'h00;
            act <= 1'h0;
        end else if (ce) begin
            if (!mst_busy) begin
                hcnt <= 5'h00;
                act <= 1'h0;
            end else if (tick) begin
                hcnt <= hcnt + 5'h01;
                act <= ~act;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt <= 4'h0;
            sact <= 1'h0;
        end else if (ce) begin
            if (done || start || !en || (slave && !ss_sel)) begin
                bcnt <= 4'h0;
            end else if (trail) begin
                bcnt <= bcnt + 4'h1;
            end
            if (done || !slave || !ss_sel) begin
                sact <= 1'h0;
            end else if (s_lead || s_trail) begin
                sact <= 1'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh <= `SMSC_DATA_RST;
            smp <= 1'h0;
            outb <= 1'h0;
        end else if (ce) begin
            if (wr_data && !busy) begin
                sh <= wb_dat_i[7:0];
            end else if (trail) begin
                sh <= {sh[6:0], shift_in};
            end
            if (lead) begin
                smp <= din;
            end
            if ((lead && ctl.phase) || !busy) begin
                outb <= sh[7];
            end
        end
    end

    // ***************************************************************
    // control registers and flags
    // ***************************************************************
    wire clr_irq = wr_stat & wb_dat_i[`SMSC_ST_IRQ];
    wire str_set = wr_ctl & wb_dat_i[`SMSC_CT_STR];
    wire irq_set = done | abort_ev | str_set;
    wire col_set = master & ~mode.select_pin_direction & ~ss_s;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= `SMSC_CTL_RST;
            mode <= `SMSC_MODE_RST;
            brh <= `SMSC_BRG_RST;
            brl <= `SMSC_BRG_RST;
        end else if (ce) begin
            if (wr_ctl) begin
                ctl <= wb_dat_i[7:0];
            end else if (clr_irq) begin
                ctl.force_interrupt <= 1'h0;
            end
            if (wr_mode) begin
                mode <= {2'h0, wb_dat_i[5:0]};
            end
            if (wr_brh) begin
                brh <= wb_dat_i[7:0];
            end
            if (wr_brl) begin
                brl <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {irq, overrun_flag, col, abort_flag} <= 4'h0;
        end else if (ce) begin
            if (!en) begin
                {irq, overrun_flag, col, abort_flag} <= 4'h0;
            end else begin
                irq <= (en & irq_set) | (irq & ~clr_irq);
                overrun_flag <= (wr_data & busy) | (overrun_flag & ~(wr_stat & wb_dat_i[`SMSC_ST_OVR]));
                col <= col_set | (col & ~(wr_stat & wb_dat_i[`SMSC_ST_COL]));
                abort_flag <= abort_ev | (abort_flag & ~(wr_stat & wb_dat_i[`SMSC_ST_ABT]));
            end
        end
    end

    // ***************************************************************
    // read mux and bus answer
    // ***************************************************************
    wire [7:0] stat = {irq, overrun_flag, col, abort_flag, 2'h0, busy, ss_s};
    wire [7:0] rd_brh = mode.diag ? cnt[15:8] : brh;
    wire [7:0] rd_brl = mode.diag ? cnt[7:0] : brl;
    wire [7:0] rd_val = !mapped ? 8'h00
                      : (idx == `SMSC_IDX_DATA) ? sh
                      : (idx == `SMSC_IDX_CTL) ? ctl
                      : (idx == `SMSC_IDX_STAT) ? stat
                      : (idx == `SMSC_IDX_MODE) ? mode
                      : (idx == `SMSC_IDX_BRH) ? rd_brh
                      : rd_brl;
    wire req = wb_cyc_i & wb_stb_i;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o) begin
                wb_dat_o <= {24'h000000, rd_val};
            end
        end
    end

    // ***************************************************************
    // pin drivers and interrupt
    // ***************************************************************
    function automatic smsc_pkg::smsc_pin_t drv(input logic on, input logic lvl, input logic od);
        smsc_pkg::smsc_pin_t p;
        p.o = od ? 1'h0 : lvl;
        p.oe = on & (od ? ~lvl : 1'h1);
        return p;
    endfunction

    wire sck_lvl = ctl.clock_idle_level ^ act;
    wire slv_drive = slave & ss_sel;
    wire ss_drive = master & mode.select_pin_direction;
    smsc_pkg::smsc_pin_t p_sck;
    smsc_pkg::smsc_pin_t p_mosi;
    smsc_pkg::smsc_pin_t p_miso;
    smsc_pkg::smsc_pin_t p_ss;
    assign p_sck = drv(master, sck_lvl, ctl.wire_or);
    assign p_mosi = drv(master, dout, ctl.wire_or);
    assign p_miso = drv(slv_drive, dout, ctl.wire_or);
    assign p_ss = drv(ss_drive, mode.select_output_value, ctl.wire_or);
    wire timeout = timer_on & tick;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {sck_o, sck_oe, mosi_o, mosi_oe} <= 4'h0;
            {miso_o, miso_oe, ss_b_o, ss_b_oe} <= 4'h0;
            irq_out <= 1'h0;
        end else if (ce) begin
            {sck_o, sck_oe, mosi_o, mosi_oe} <= {p_sck, p_mosi};
            {miso_o, miso_oe, ss_b_o, ss_b_oe} <= {p_miso, p_ss};
            irq_out <= (ctl.interrupt_enable & irq) | timeout;
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ovr_on_busy: assert property (ce && en && wr_data && busy |=> overrun_flag)
        else $error("overrun not flagged");
    a_col_on_select: assert property (ce && col_set |=> col)
        else $error("collision not flagged");
    a_abort_flags: assert property (ce && abort_ev |=> abort_flag && irq && bcnt == 4'h0)
        else $error("abort flags missing");
    a_irq_clear: assert property (ce && en && clr_irq && !irq_set |=> !irq)
        else $error("pending not cleared");
    a_force_irq: assert property (ce && en && str_set |=> irq && ctl.force_interrupt)
        else $error("forced interrupt missing");
    a_timer_no_flag: assert property (ce && timeout |=> irq_out && !irq)
        else $error("timer interrupt wrong");
    a_sck_idle: assert property (ce && master && !mst_busy && !ctl.wire_or
        |=> sck_o == $past(ctl.clock_idle_level))
        else $error("clock not idle");
    a_miso_release: assert property (ce && !slv_drive |=> !miso_oe)
        else $error("miso driven when not selected");
    a_start_load: assert property (ce && start |=> mst_busy && sh == $past(wb_dat_i[7:0]) && bcnt == 4'h0)
        else $error("transfer start wrong");
    a_done_count: assert property (ce && done |-> bcnt == len - 4'h1 ##1 bcnt == 4'h0)
        else $error("character length wrong");

    c_master_done: cover property (mst_busy && done);
    c_slave_done: cover property (slave && done);
    c_slave_abort: cover property (abort_ev);
    c_timer_out: cover property (timeout);

endmodule
`default_nettype wire

// file: core/smsc_consts.svh
// constants of the serial port core: register indices, reset values,
// status bit positions and fixed counts.
// assumes inclusion by bare name from the core's module.
`ifndef SMSC_CONSTS_SVH
`define SMSC_CONSTS_SVH

// register index; byte address is four times the index
`define SMSC_IDX_DATA 3'h0
`define SMSC_IDX_CTL 3'h1
`define SMSC_IDX_STAT 3'h2
`define SMSC_IDX_MODE 3'h3
`define SMSC_IDX_BRH 3'h4
`define SMSC_IDX_BRL 3'h5

// reset values
`define SMSC_CTL_RST 8'h00
`define SMSC_MODE_RST 8'h00
`define SMSC_BRG_RST 8'h00
`define SMSC_DATA_RST 8'h00

// status bit positions, write one to clear
`define SMSC_ST_IRQ 7
`define SMSC_ST_OVR 6
`define SMSC_ST_COL 5
`define SMSC_ST_ABT 4
// control bit position of the forced interrupt
`define SMSC_CT_STR 6

// character length for code zero
`define SMSC_LEN_FULL 4'h8

`endif

// file: core/smsc_pkg.sv
// types of the serial port core.
// assumes smsc_consts.svh sits beside this file.
package smsc_pkg;

    typedef struct packed {
        logic interrupt_enable;
        logic force_interrupt;
        logic timer_interrupt_enable;
        logic phase;
        logic clock_idle_level;
        logic wire_or;
        logic master_mode_enable;
        logic port_enable;
    } smsc_ctl_t;

    typedef struct packed {
        logic [1:0] rsv;
        logic diag;
        logic [2:0] character_length;
        logic select_pin_direction;
        logic select_output_value;
    } smsc_mode_t;

    typedef struct packed {
        logic o;
        logic oe;
    } smsc_pin_t;

    typedef enum logic {M_IDLE, M_SHIFT} smsc_mstate_t;

endpackage

// file: testbench/smsc_peer.sv
// far-end model: a serial slave of selectable phase and polarity.
// assumes the bench resolves the pins; released lines read high.
`timescale 1ns/1ps
`default_nettype none
module smsc_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_b,
    input wire logic phase,
    input wire logic pol,
    input wire logic [7:0] tx,
    output logic miso,
    output logic miso_oe,
    output logic [7:0] rx,
    output logic [3:0] n_lead
);
    // ****************
    // shift engine
    // ****************
    logic [7:0] sh;
    logic lead;
    assign miso_oe = !ss_b;
    initial begin
        miso = 1'b0;
        rx = 8'h00;
        n_lead = 4'h0;
        sh = 8'h00;
    end
    always @(negedge ss_b) begin
        sh = tx;
        rx = 8'h00;
        n_lead = 4'h0;
        if (!phase) begin
            miso = sh[7];
            sh = sh << 1;
        end
    end
    always @(sck) begin
        if (!ss_b) begin
            lead = (sck !== pol);
            n_lead = n_lead + {3'h0, lead};
            if (lead ^ phase) begin
                rx = {rx[6:0], mosi};
            end else begin
                miso = sh[7];
                sh = sh << 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/smsc_core_test.sv
// self-checking bench of the serial port core with a slave model.
// assumes classic wishbone registers as the core's notes map them.
`timescale 1ns/1ps
`default_nettype none
module smsc_core_test;
    // ****************
    // signals
    // ****************
    logic sys_clk = 1'b0;
    logic rst_b, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_b_o, ss_b_oe, irq_out;
    logic tb_drv, tb_sck, tb_mosi, tb_ss_b, p_ph, p_po;
    logic [7:0] p_tx;
    wire logic [7:0] p_rx;
    wire logic [3:0] p_n;
    wire logic p_miso, p_oe;
    int errors = 0;
    int n_compared = 0;
    wire logic sck_w = sck_oe ? sck_o : (tb_drv ? tb_sck : 1'b1);
    wire logic mosi_w = mosi_oe ? mosi_o : (tb_drv ? tb_mosi : 1'b1);
    wire logic miso_w = miso_oe ? miso_o : (p_oe ? p_miso : 1'b1);
    wire logic ss_w = ss_b_oe ? ss_b_o : tb_ss_b;
    always #20 sys_clk = ~sys_clk;
    smsc_core i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_b_i(ss_w), .ss_b_o(ss_b_o),
        .ss_b_oe(ss_b_oe), .irq_out(irq_out));
    smsc_peer i_peer (.sck(sck_w), .mosi(mosi_w), .ss_b(ss_w), .phase(p_ph), .pol(p_po),
        .tx(p_tx), .miso(p_miso), .miso_oe(p_oe), .rx(p_rx), .n_lead(p_n));
    // ****************
    // shared tasks
    // ****************
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task cyc_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] q);
        wb(a, 1'b0, 8'h00, q);
    endtask
    task sbits(input logic [7:0] o, input int n, output logic [7:0] i);
        i = 8'h00;
        for (int k = 0; k < n; k++) begin
            tb_mosi <= o[7 - k];
            cyc_n(6);
            tb_sck <= 1'b1;
            i = {i[6:0], miso_w};
            cyc_n(6);
            tb_sck <= 1'b0;
        end
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task t_regs;
        logic [7:0] q;
        rd(8'h04, q); chk("ctl reset", q, 8'h00);
        rd(8'h0C, q); chk("mode reset", q, 8'h00);
        rd(8'h08, q); chk("stat reset", q, 8'h01);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, q); chk("mode rsv", q, 8'h3F);
        wr(8'h0C, 8'h00);
        wr(8'h18, 8'hFF);
        rd(8'h18, q); chk("unmapped", q, 8'h00);
        $display("test regs done");
    endtask
    task t_force;
        logic [7:0] q;
        wr(8'h04, 8'h01);
        wr(8'h04, 8'hC1);
        cyc_n(2);
        chk("force line", {7'h00, irq_out}, 8'h01);
        rd(8'h08, q); chk("force stat", q & 8'h80, 8'h80);
        wr(8'h08, 8'h80);
        cyc_n(2);
        chk("clear line", {7'h00, irq_out}, 8'h00);
        rd(8'h04, q); chk("force bit", q, 8'h81);
        $display("test force done");
    endtask
    task t_timer;
        logic [7:0] q;
        int n;
        wr(8'h04, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h03);
        wr(8'h04, 8'h20);
        n = 0;
        while (irq_out !== 1'b1 && n < 99) begin
            @(posedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        chk("pulse width", {7'h00, irq_out}, 8'h00);
        n = 0;
        while (irq_out !== 1'b1 && n < 99) begin
            @(posedge sys_clk);
            n++;
        end
        chk("timer gap", n[7:0], 8'h02);
        rd(8'h08, q); chk("timer stat", q, 8'h01);
        wr(8'h04, 8'h00);
        $display("test timer done");
    endtask
    task t_master(input logic ph, input logic po, input logic [2:0] code, input logic [7:0] tx,
        input logic [7:0] ptx);
        logic [7:0] q, nb, m;
        logic s;
        int n;
        nb = (code == 3'h0) ? 8'h08 : {5'h00, code};
        m = 8'hFF >> (8'h08 - nb);
        p_ph = ph;
        p_po = po;
        p_tx = ptx;
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h04);
        wr(8'h0C, {3'h0, code, 2'h3});
        wr(8'h04, {3'h4, ph, po, 3'h3});
        wr(8'h0C, {3'h0, code, 2'h2});
        chk("sck idle", {7'h00, sck_w}, {7'h00, po});
        wr(8'h00, tx);
        wr(8'h00, 8'hFF);
        for (int k = 0; k < 2; k++) begin
            s = sck_w;
            n = 0;
            while (sck_w === s && n < 99) begin
                @(posedge sys_clk);
                n++;
            end
        end
        chk("half period", n[7:0], 8'h04);
        n = 0;
        do begin
            rd(8'h08, q);
            n++;
        end while (q[1] !== 1'b0 && n < 60);
        chk("master stat", q, 8'hC0);
        chk("irq line", {7'h00, irq_out}, 8'h01);
        chk("peer got", p_rx, tx >> (8'h08 - nb));
        chk("edge count", {4'h0, p_n}, nb);
        rd(8'h00, q); chk("master in", q & m, ptx >> (8'h08 - nb));
        wr(8'h08, 8'hC0);
        rd(8'h08, q); chk("flags clear", q, 8'h00);
        $display("test master done");
    endtask
    task t_coll;
        logic [7:0] q;
        wr(8'h0C, 8'h00);
        wr(8'h04, 8'h03);
        tb_ss_b <= 1'b0;
        cyc_n(6);
        rd(8'h08, q); chk("col set", q, 8'h20);
        tb_ss_b <= 1'b1;
        cyc_n(6);
        wr(8'h08, 8'h20);
        rd(8'h08, q); chk("col clear", q, 8'h01);
        $display("test collision done");
    endtask
    task t_slave;
        logic [7:0] q;
        wr(8'h04, 8'h00);
        tb_drv <= 1'b1;
        wr(8'h14, 8'h01);
        wr(8'h0C, 8'h00);
        wr(8'h04, 8'h81);
        wr(8'h00, 8'h96);
        tb_ss_b <= 1'b0;
        cyc_n(8);
        sbits(8'h5A, 8, q); chk("slave out", q, 8'h96);
        cyc_n(8);
        rd(8'h08, q); chk("slave done", q, 8'h80);
        rd(8'h00, q); chk("slave in", q, 8'h5A);
        wr(8'h08, 8'h80);
        wr(8'h00, 8'hC3);
        sbits(8'h0F, 8, q); chk("second out", q, 8'hC3);
        cyc_n(8);
        rd(8'h08, q); chk("second done", q, 8'h80);
        wr(8'h08, 8'h80);
        wr(8'h00, 8'h2C);
        sbits(8'hE0, 3, q);
        cyc_n(8);
        tb_ss_b <= 1'b1;
        cyc_n(8);
        rd(8'h08, q); chk("abort", q, 8'h91);
        wr(8'h08, 8'h90);
        tb_ss_b <= 1'b0;
        cyc_n(8);
        sbits(8'h00, 8, q); chk("restart", q, 8'h67);
        tb_ss_b <= 1'b1;
        tb_drv <= 1'b0;
        $display("test slave done");
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        rst_b = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        {tb_drv, tb_sck, tb_mosi, p_ph, p_po} = 5'h00;
        tb_ss_b = 1'b1;
        p_tx = 8'h00;
        cyc_n(16);
        rst_b <= 1'b1;
        cyc_n(3);
        t_regs;
        t_force;
        t_timer;
        t_master(1'b0, 1'b0, 3'h0, 8'hA5, 8'h3C);
        t_master(1'b0, 1'b1, 3'h0, 8'h5A, 8'hC3);
        t_master(1'b1, 1'b0, 3'h0, 8'h96, 8'h69);
        t_master(1'b1, 1'b1, 3'h0, 8'hF0, 8'h0F);
        t_master(1'b0, 1'b0, 3'h3, 8'h60, 8'hA0);
        t_coll;
        t_slave;
        wrap_up;
    end
    initial begin
        cyc_n(40000);
        errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
